// file: bgdml_host.sv
// Host controller that drives a synchronous buck power stage through its pins.
// Assumes all user inputs and the fault flag input are synchronous to clk_in.
`timescale 1ns/1ps

// Functional notes
// R1: Mode-select high means synchronous operation, low means independent operation.
// R2: Synchronous mode: pulse-width high turns high side on, low side off.
// R3: Synchronous mode: pulse-width low turns low side on if rectifier enabled.
// R4: Synchronous mode: device confirms one gate off before turning the other on.
// R5: Synchronous mode: rectifier-enable low keeps the low-side gate off.
// R6: Synchronous mode with rectifier-enable high allows commanded low-side switching.
// R7: Independent mode: high-side gate follows the pulse-width input alone.
// R8: Independent mode: low-side gate follows rectifier-enable directly.
// R9: Independent mode: no dead time or interlock between gates.
// R10: Independent mode: controller never drives pulse-width and rectifier-enable high together.
// R11: Mid-level pulse-width input past hold-off forces both gates off.
// R12: Leaving tri-state, controller drives pulse-width low first to recharge bootstrap.
// R13: Undriven rectifier-enable reads high through an internal pull-up.
// R14: Mode-select stays fixed while the stage operates.
// R15: Regulator-disable stays fixed while the stage operates.
// R16: No gate pulses while gate supply is below undervoltage lockout.
// R17: Fault flag is high while gate supply is below undervoltage lockout.
// R18: Fault flag is low during normal fault-free operation.
// R19: Tri-state hold-off is a cycle count from a mid-level detect input.
// R20: Interlock waits for gate-off confirmation before turning the opposite gate on.
module bgdml_host (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic enable_in,
   input wire logic sync_mode_in,
   input wire logic regulator_disable_in,
   input wire logic rect_enable_in,
   input wire logic tristate_req_in,
   input wire logic [bgdml_pkg::DUTY_W-1:0] duty_in,
   input wire logic fault_flag_in,
   output logic pwm_out,
   output logic pwm_oe_out,
   output logic sync_rect_enable_out,
   output logic drive_mode_select_out,
   output logic gate_regulator_disable_out,
   output logic running_out,
   output logic fault_seen_out
);
   import bgdml_pkg::*;

   typedef struct packed {
      bgdml_state_t st;
      logic [DUTY_W-1:0] cnt;
      logic pwm;
      logic pwm_oe;
      logic sync_rect_enable;
      logic mode;
      logic regdis;
      logic running;
      logic fault;
   } bgdml_host_t;

   bgdml_host_t cur_ff;
   bgdml_host_t nxt_cur;
   logic want_hi;

   // ==========================================================================
   // Pulse-width source
   bgdml_pwm_gen bgdml_pwm_gen_inst (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .run_in(cur_ff.st == ST_RUN),
      .duty_in(duty_in),
      .pwm_hi_out(want_hi)
   );

   // ==========================================================================
   // Sequencing and pin drive
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.pwm_oe = 1'b1;
      nxt_cur.running = 1'b0;
      unique case (cur_ff.st)
         ST_IDLE: begin
            nxt_cur.pwm = 1'b0;
            nxt_cur.sync_rect_enable = 1'b0;
            nxt_cur.mode = sync_mode_in; // R14
            nxt_cur.regdis = regulator_disable_in; // R15
            if (enable_in && !tristate_req_in) begin
               nxt_cur.st = ST_PRECHARGE;
               nxt_cur.cnt = CNT_RESET;
               nxt_cur.fault = 1'b0;
            end
         end
         ST_PRECHARGE: begin
            nxt_cur.pwm = 1'b0; // R12
            nxt_cur.sync_rect_enable = rect_enable_in;
            if (fault_flag_in) begin
               nxt_cur.cnt = CNT_RESET; // R16
            end else if (cur_ff.cnt == PRECHARGE_LAST) begin
               nxt_cur.st = ST_RUN;
               nxt_cur.running = 1'b1;
            end else begin
               nxt_cur.cnt = 8'(cur_ff.cnt + 8'h01);
            end
            if (!enable_in) begin
               nxt_cur.st = ST_IDLE;
               nxt_cur.running = 1'b0;
            end
         end
         ST_RUN: begin
            nxt_cur.running = 1'b1;
            if (cur_ff.mode) begin
               nxt_cur.pwm = want_hi;
               nxt_cur.sync_rect_enable = rect_enable_in;
            end else begin
               nxt_cur.pwm = want_hi && !cur_ff.sync_rect_enable; // R10
               nxt_cur.sync_rect_enable = rect_enable_in && !want_hi && !cur_ff.pwm; // R10
            end
            if (fault_flag_in) begin
               nxt_cur.st = ST_IDLE; // R17
               nxt_cur.fault = 1'b1;
               nxt_cur.running = 1'b0;
               nxt_cur.pwm = 1'b0;
               nxt_cur.sync_rect_enable = 1'b0;
            end else if (!enable_in) begin
               nxt_cur.st = ST_IDLE;
               nxt_cur.running = 1'b0;
               nxt_cur.pwm = 1'b0;
               nxt_cur.sync_rect_enable = 1'b0;
            end else if (tristate_req_in) begin
               nxt_cur.st = ST_TRISTATE;
               nxt_cur.running = 1'b0;
               nxt_cur.pwm = 1'b0;
               nxt_cur.pwm_oe = 1'b0;
               nxt_cur.sync_rect_enable = 1'b0;
            end
         end
         ST_TRISTATE: begin
            nxt_cur.pwm = 1'b0;
            nxt_cur.sync_rect_enable = 1'b0;
            nxt_cur.pwm_oe = 1'b0;
            if (!enable_in) begin
               nxt_cur.st = ST_IDLE;
               nxt_cur.pwm_oe = 1'b1;
            end else if (!tristate_req_in) begin
               nxt_cur.st = ST_PRECHARGE; // R12
               nxt_cur.cnt = CNT_RESET;
               nxt_cur.pwm_oe = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cur_ff.st <= ST_IDLE;
         cur_ff.cnt <= CNT_RESET;
         cur_ff.pwm <= PIN_RESET;
         cur_ff.pwm_oe <= PWM_OE_RESET;
         cur_ff.sync_rect_enable <= PIN_RESET;
         cur_ff.mode <= PIN_RESET;
         cur_ff.regdis <= PIN_RESET;
         cur_ff.running <= PIN_RESET;
         cur_ff.fault <= PIN_RESET;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign pwm_out = cur_ff.pwm;
   assign pwm_oe_out = cur_ff.pwm_oe;
   assign sync_rect_enable_out = cur_ff.sync_rect_enable;
   assign drive_mode_select_out = cur_ff.mode;
   assign gate_regulator_disable_out = cur_ff.regdis;
   assign running_out = cur_ff.running;
   assign fault_seen_out = cur_ff.fault;

   // ==========================================================================
   // Checks
   sequence s_leave_tristate;
      (cur_ff.st == ST_TRISTATE) ##1 (cur_ff.st != ST_TRISTATE);
   endsequence

   sequence s_low_driven_8;
      (pwm_oe_out && !pwm_out)[*8];
   endsequence

   a_no_overlap_indep: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R10
      !drive_mode_select_out |-> !(pwm_out && sync_rect_enable_out))
      else $error("pulse-width and rectifier-enable high together in independent mode");

   a_tristate_exit_low: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R12
      s_leave_tristate |-> s_low_driven_8)
      else $error("pulse-width not driven low after leaving tri-state");

   a_mode_held: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R14
      (cur_ff.st != ST_IDLE) ##1 (cur_ff.st != ST_IDLE) |-> $stable(drive_mode_select_out))
      else $error("mode select changed while operating");

   a_regdis_held: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R15
      (cur_ff.st != ST_IDLE) ##1 (cur_ff.st != ST_IDLE) |-> $stable(gate_regulator_disable_out))
      else $error("regulator disable changed while operating");

   a_fault_stops: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R17
      (cur_ff.st == ST_RUN) && fault_flag_in |=> !running_out && !pwm_out && fault_seen_out)
      else $error("switching continued after fault flag");

   a_run_needs_good: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R16
      $rose(running_out) |-> !$past(fault_flag_in) && (pwm_oe_out && !pwm_out))
      else $error("switching started without supply good");

   a_precharge_low: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R12
      (cur_ff.st == ST_PRECHARGE) |-> pwm_oe_out && !pwm_out)
      else $error("pulse-width pin not held low during precharge");

   a_tristate_release: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R11
      (cur_ff.st == ST_TRISTATE) |-> !pwm_oe_out && !sync_rect_enable_out)
      else $error("pulse-width pin still driven in tri-state");

   a_pwm_rise_gap: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R10
      !drive_mode_select_out && $rose(pwm_out) |-> !$past(sync_rect_enable_out))
      else $error("pulse-width rose right after rectifier-enable in independent mode");

   a_rect_rise_gap: assert property (@(posedge clk_in) disable iff (!arst_n_in) // R10
      !drive_mode_select_out && $rose(sync_rect_enable_out) |-> !$past(pwm_out))
      else $error("rectifier-enable rose right after pulse-width in independent mode");

endmodule

// file: bgdml_host_tb_top.sv
// Self-checking bench for the host controller against the stage model.
// Assumes the package, the design and the stage model are compiled first.
`timescale 1ns/1ps

module bgdml_host_tb_top;
   import bgdml_pkg::*;
   logic clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic en = 1'b0, smode = 1'b0, rdis = 1'b0, rect = 1'b0, treq = 1'b0, good = 1'b1;
   logic [DUTY_W-1:0] duty = 8'h00;
   logic fault_flag, pwm, oe, sync_rect_enable, mode, gdis, run, fseen, hs, ls;
   int seed = 10;
   int n_fail = 0;
   int checks = 0;
   always #5 clk_in = ~clk_in;
   bgdml_host bgdml_host_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .enable_in(en),
      .sync_mode_in(smode), .regulator_disable_in(rdis), .rect_enable_in(rect),
      .tristate_req_in(treq), .duty_in(duty), .fault_flag_in(fault_flag), .pwm_out(pwm),
      .pwm_oe_out(oe), .sync_rect_enable_out(sync_rect_enable), .drive_mode_select_out(mode),
      .gate_regulator_disable_out(gdis), .running_out(run), .fault_seen_out(fseen));
   bgdml_stage_model bgdml_stage_model_inst (.clk_in(clk_in), .arst_n_in(arst_n_in),
      .pwm_in(pwm), .pwm_oe_in(oe), .sre_in(sync_rect_enable), .mode_in(mode), .supply_good_in(good),
      .hs_out(hs), .ls_out(ls), .fault_flag_out(fault_flag));
   // ==========
   // Checks
   task automatic chk_bit(input string what, input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic chk_cnt(input string what, input int exp, input int got);
      checks++;
      if (got != exp) begin
         n_fail++;
         $display("ERROR %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   task automatic final_report();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   function automatic int exp_highs(input logic [DUTY_W-1:0] d);
      return 2 * int'(d);
   endfunction
   task automatic wait_run(output int n);
      n = 0;
      while (run !== 1'b1 && n < 400) begin
         @(negedge clk_in);
         n++;
      end
   endtask
   task automatic watch(input logic sm, input int cyc, output int highs);
      highs = 0;
      repeat (cyc) begin
         @(negedge clk_in);
         highs += int'(pwm === 1'b1);
         chk_bit("gate overlap", 1'b0, hs & ls);
         if (sm) chk_bit("rect pin", rect, sync_rect_enable);
         else chk_bit("pin overlap", 1'b0, pwm & sync_rect_enable);
      end
   endtask
   // ==========
   // Scenarios
   initial begin
      int n, h;
      repeat (6) @(negedge clk_in);
      arst_n_in = 1'b1;
      chk_bit("pwm oe reset", 1'b1, oe);
      chk_bit("pwm reset", 1'b0, pwm);
      for (int m = 1; m >= 0; m--) begin
         smode = m[0];
         rdis = ~m[0];
         rect = m[0] ? 1'($random(seed)) : 1'b1;
         duty = m[0] ? 8'($unsigned($random(seed)) % 201) : 8'hc8;
         en = 1'b1;
         wait_run(n);
         chk_cnt("start latency", int'(PRECHARGE_CYCLES) + 1, n);
         chk_bit("mode pin", m[0], mode);
         chk_bit("regulator pin", ~m[0], gdis);
         chk_bit("fault seen clear", 1'b0, fseen);
         smode = ~m[0];
         watch(m[0], 401, h);
         if (m[0]) chk_cnt("pwm high cycles", exp_highs(duty), h);
         chk_bit("mode pin held", m[0], mode);
         smode = m[0];
         treq = 1'b1;
         @(negedge clk_in);
         chk_bit("pwm oe off", 1'b0, oe);
         repeat (8) @(negedge clk_in);
         chk_bit("gates off", 1'b0, hs | ls);
         treq = 1'b0;
         repeat (100) begin
            @(negedge clk_in);
            chk_bit("pwm low after tristate", 1'b0, pwm | ~oe);
         end
         wait_run(n);
         chk_bit("running again", 1'b1, run);
         good = 1'b0;
         @(negedge clk_in);
         chk_bit("fault flag", 1'b1, fault_flag);
         chk_bit("fault seen", 1'b1, fseen);
         chk_bit("gates on fault", 1'b0, hs | ls | pwm | run);
         good = 1'b1;
         en = 1'b0;
         repeat (3) @(negedge clk_in);
         chk_bit("fault flag clear", 1'b0, fault_flag);
      end
      final_report();
   end
   // Limit sits far above the roughly 1250 cycles that the scenarios take.
   initial begin
      #200000;
      n_fail++;
      final_report();
   end
endmodule

// file: bgdml_pkg.sv
// Constants, timing counts and state types of the buck gate-drive host controller.
// Assumes a single 100 MHz clock and an active-low asynchronous reset.
package bgdml_pkg;

   // ==========================================================================
   // Timing
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned BOOT_PRECHARGE_NS = 1000;
   localparam int unsigned PRECHARGE_CYCLES =
      (BOOT_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================================
   // Widths and counts
   localparam int unsigned DUTY_W = 8;
   localparam logic [DUTY_W-1:0] PWM_LAST_COUNT = 8'hc7;
   localparam logic [DUTY_W-1:0] PRECHARGE_LAST = 8'(PRECHARGE_CYCLES - 1);

   // ==========================================================================
   // Values after reset
   localparam logic [DUTY_W-1:0] CNT_RESET = 8'h00;
   localparam logic PIN_RESET = 1'b0;
   localparam logic PWM_OE_RESET = 1'b1;

   // ==========================================================================
   // Controller states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_PRECHARGE,
      ST_RUN,
      ST_TRISTATE
   } bgdml_state_t;

endpackage

// file: bgdml_pwm_gen.sv
// Free-running pulse-width generator for the host controller.
// Assumes the duty input is held steady by the user; a restart clears the period.
`timescale 1ns/1ps

module bgdml_pwm_gen (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic run_in,
   input wire logic [bgdml_pkg::DUTY_W-1:0] duty_in,
   output logic pwm_hi_out
);
   import bgdml_pkg::*;

   typedef struct packed {
      logic [DUTY_W-1:0] cnt;
      logic hi;
   } bgdml_gen_t;

   bgdml_gen_t cur_ff;
   bgdml_gen_t nxt_cur;

   // ==========================================================================
   // Period counter and compare
   always_comb begin
      nxt_cur = cur_ff;
      if (!run_in) begin
         nxt_cur.cnt = CNT_RESET;
         nxt_cur.hi = 1'b0;
      end else begin
         nxt_cur.cnt = (cur_ff.cnt == PWM_LAST_COUNT) ? CNT_RESET : 8'(cur_ff.cnt + 8'h01);
         nxt_cur.hi = (cur_ff.cnt < duty_in);
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign pwm_hi_out = cur_ff.hi;

endmodule

// file: bgdml_stage_model.sv
// Behavioural power stage that answers the host controller's pins.
// Assumes the host drives its pins from the same clock and reset.
`timescale 1ns/1ps

module bgdml_stage_model #(
   parameter int HOLDOFF = 4
) (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic pwm_in,
   input wire logic pwm_oe_in,
   input wire logic sre_in,
   input wire logic mode_in,
   input wire logic supply_good_in,
   output logic hs_out,
   output logic ls_out,
   output logic fault_flag_out
);
   // ==========
   // Gate logic
   int mid_cnt;
   logic sre_pin;
   assign sre_pin = (sre_in !== 1'b0);
   assign fault_flag_out = !supply_good_in;
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         mid_cnt <= 0;
         hs_out <= 1'b0;
         ls_out <= 1'b0;
      end else begin
         mid_cnt <= pwm_oe_in ? 0 : ((mid_cnt < HOLDOFF) ? mid_cnt + 1 : mid_cnt);
         if (!supply_good_in || mid_cnt >= HOLDOFF) begin
            hs_out <= 1'b0;
            ls_out <= 1'b0;
         end else if (mode_in) begin
            hs_out <= pwm_in && !ls_out;
            ls_out <= !pwm_in && sre_pin && !hs_out;
         end else begin
            hs_out <= pwm_in;
            ls_out <= sre_pin;
         end
      end
   end
endmodule
